// ### hw/core_cycle_timing_irq_ack.sv
/*
 machine cycle sequencer, wait states, interrupt acknowledge and
 external memory strobes of an 8-bit core.
 assumes the decoder presents the next instruction's info at every
 instruction boundary and that interrupt flags arrive already enabled.
*/
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
module core_cycle_timing_irq_ack
   import cyc_timing_pkg::*;
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                resetn,
   // wishbone slave
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [3:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   // decoder side
   input  wire instr_info_t         next_instr,
   input  wire logic [19:0]         pc,
   input  wire logic                sfr_wr_req,
   output logic                     sfr_wr_commit,
   output logic                     phase_one,
   output logic                     phase_two,
   output logic                     instr_load,
   // interrupt side
   input  wire logic [NSRC-1:0]     irq_pend,
   input  wire logic [NSRC-1:0]     irq_lvl_hi,
   input  wire logic [NSRC-1:0]     irq_lvl_lo,
   output logic                     irq_ack,
   output logic [3:0]               irq_src,
   output logic                     call_active,
   // data move side
   input  wire logic                xmove_go,
   input  wire xmove_req_t          xmove,
   output logic                     xmove_done,
   output logic                     xmove_internal,
   output logic [7:0]               xmove_rdata,
   // external memory pins
   input  wire logic                external_access_select_n,
   output logic                     program_fetch_strobe_n,
   output logic                     read_strobe_n,
   output logic                     write_strobe_n,
   output logic [19:0]              ext_addr,
   input  wire logic [7:0]          dbus_in,
   output logic [7:0]               dbus_out,
   output logic                     dbus_oe
);

   typedef enum logic [0:0] {S_EXEC, S_CALL} seq_t;

   seq_t        state_r;
   logic        phase_r;
   logic [3:0]  cyc_left_r;
   logic [1:0]  call_cnt_r;
   logic        blk_r;
   logic        return_from_interrupt_op_r;
   logic [NSRC-1:0] samp_r;
   logic [4:0]  inprog_r;
   logic [3:0]  last_src_r;
   logic [3:0]  wait_cfg_r;
   logic        ea_s1_r, ea_s2_r;
   logic [7:0]  db_s1_r, db_s2_r;
   logic        xm_busy_r;
   logic        xm_we_r;
   logic [2:0]  xm_left_r;
   logic        ack_r;
   logic [31:0] rdat_r;

   logic        p2;
   logic        last_cyc;
   logic        instr_end;
   logic        ext_prog;
   logic [1:0]  ws_fetch;
   logic [3:0]  load_len;
   logic [2:0]  cur_lvl;
   logic [2:0]  best_lvl;
   logic [3:0]  best_src;
   logic        best_ok;
   logic        irq_go;
   logic [19:0] xm_addr;
   logic        xm_ext;
   logic [2:0]  src_lvl [NSRC];

   assign p2        = phase_r;
   assign phase_one = ~phase_r;
   assign phase_two = phase_r;
   assign last_cyc  = (cyc_left_r == 4'h0);
   assign instr_end = p2 & last_cyc & (state_r == S_EXEC);
   assign call_active = (state_r == S_CALL);

   // two phases per machine cycle, phase one first after reset
   always_ff @(posedge clk) begin
      if (!resetn) begin
         phase_r <= 1'b0;
      end else begin
         phase_r <= ~phase_r;
      end
   end

   // register writes only land on the closing phase
   assign sfr_wr_commit = sfr_wr_req & p2;

   // pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ea_s1_r <= 1'b1;
         ea_s2_r <= 1'b1;
         db_s1_r <= 8'h00;
         db_s2_r <= 8'h00;
      end else begin
         ea_s1_r <= external_access_select_n;
         ea_s2_r <= ea_s1_r;
         db_s1_r <= dbus_in;
         db_s2_r <= db_s1_r;
      end
   end

   // code region or the external access pin decides external fetch and its wait count
   assign ext_prog = ~ea_s2_r | (pc >= INT_CODE_SIZE);
   assign ws_fetch = ext_prog ? wait_cfg_r[WS_EXT_POS +: 2] : wait_cfg_r[WS_INT_POS +: 2];

   // length of the next instruction in machine cycles minus one
   always_comb begin
      logic [3:0] base;
      base = 4'h3;
      unique case (next_instr.cyc_code)
         CYC1:    base = 4'h0;
         CYC2:    base = 4'h1;
         default: base = 4'h3;
      endcase
      load_len = base + 4'(next_instr.bytes * ws_fetch);
   end

   // current in-progress level: 0 none, 1..4 maskable, 5 nonmaskable
   always_comb begin
      cur_lvl = 3'h0;
      for (int i = 0; i < 5; i++) begin
         if (inprog_r[i]) begin
            cur_lvl = 3'(i + 1);
         end
      end
   end

   // level of each source; nonmaskable sits above every maskable level
   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_lvl
         if (g == 0) begin : g_nmi
            assign src_lvl[g] = NMI_LEVEL;
         end else begin : g_mask
            assign src_lvl[g] = {1'b0, irq_lvl_hi[g], irq_lvl_lo[g]} + 3'h1;
         end
      end
   endgenerate

   // poll the sampled flags: highest level, then lowest index
   always_comb begin
      best_lvl = 3'h0;
      best_src = 4'h0;
      best_ok  = 1'b0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (samp_r[i] && src_lvl[i] >= best_lvl) begin
            best_lvl = src_lvl[i];
            best_src = 4'(i);
            best_ok  = 1'b1;
         end
      end
   end

   // only present flags count, so a denied request is simply dropped
   assign irq_go = instr_end & best_ok & (best_lvl > cur_lvl) & ~blk_r;

   // sample requests at phase two for the next cycle's poll
   always_ff @(posedge clk) begin
      if (!resetn) begin
         samp_r <= '0;
      end else if (p2) begin
         samp_r <= irq_pend;
      end
   end

   // instruction and call sequencing
   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_r    <= S_EXEC;
         cyc_left_r <= 4'h0;
         call_cnt_r <= 2'h0;
         blk_r      <= 1'b0;
         return_from_interrupt_op_r     <= 1'b0;
      end else if (p2) begin
         unique case (state_r)
            S_EXEC: begin
               if (irq_go) begin
                  state_r    <= S_CALL;
                  call_cnt_r <= CALL_CYCLES - 2'h1;
                  blk_r      <= 1'b0;
                  return_from_interrupt_op_r     <= 1'b0;
               end else if (last_cyc) begin
                  cyc_left_r <= load_len;
                  blk_r      <= next_instr.return_from_interrupt_op | next_instr.ie_write;
                  return_from_interrupt_op_r     <= next_instr.return_from_interrupt_op;
               end else begin
                  cyc_left_r <= cyc_left_r - 4'h1;
               end
            end
            S_CALL: begin
               if (call_cnt_r == 2'h0) begin
                  state_r    <= S_EXEC;
                  cyc_left_r <= load_len;
                  blk_r      <= next_instr.return_from_interrupt_op | next_instr.ie_write;
                  return_from_interrupt_op_r     <= next_instr.return_from_interrupt_op;
               end else begin
                  call_cnt_r <= call_cnt_r - 2'h1;
               end
            end
         endcase
      end
   end

   // load strobe at end of phase two of the last cycle or call end
   assign instr_load = p2 & last_cyc & (state_r == S_EXEC) & ~irq_go
                     | p2 & (state_r == S_CALL) & (call_cnt_r == 2'h0);

   // in-progress levels: set by the call, top one cleared by return
   always_ff @(posedge clk) begin
      if (!resetn) begin
         inprog_r   <= 5'h00;
         last_src_r <= 4'h0;
      end else if (irq_go) begin
         inprog_r[best_lvl - 3'h1] <= 1'b1;
         last_src_r <= best_src;
      end else if (instr_end && return_from_interrupt_op_r && cur_lvl != 3'h0) begin
         inprog_r[cur_lvl - 3'h1] <= 1'b0;
      end
   end

   // one pulse per acknowledge so the source may clear its flag
   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq_ack <= 1'b0;
         irq_src <= 4'h0;
      end else begin
         irq_ack <= irq_go;
         if (irq_go) begin
            irq_src <= best_src;
         end
      end
   end

   // data address: bank above 16-bit pointer or port page plus index
   assign xm_addr = {xmove.data_bank_field,
                     xmove.use_data_pointer ? xmove.data_pointer : {xmove.port_high, xmove.index_reg}};
   assign xm_ext  = (xm_addr >= INT_CODE_SIZE);

   // data move: one machine cycle plus external wait states; a read holds one cycle more
   // so the two-flop bus sample taken at release still comes from inside the strobe
   always_ff @(posedge clk) begin
      if (!resetn) begin
         xm_busy_r      <= 1'b0;
         xm_we_r        <= 1'b0;
         xm_left_r      <= 3'h0;
         xmove_done     <= 1'b0;
         xmove_internal <= 1'b0;
         xmove_rdata    <= 8'h00;
         read_strobe_n  <= 1'b1;
         write_strobe_n <= 1'b1;
         dbus_out       <= 8'h00;
         dbus_oe        <= 1'b0;
      end else begin
         xmove_done <= 1'b0;
         if (!xm_busy_r && xmove_go && p2) begin
            xmove_internal <= ~xm_ext;
            if (xm_ext) begin
               xm_busy_r      <= 1'b1;
               xm_we_r        <= xmove.we;
               xm_left_r      <= {1'b0, wait_cfg_r[WS_EXT_POS +: 2]} + {2'h0, ~xmove.we};
               read_strobe_n  <= xmove.we;
               write_strobe_n <= ~xmove.we;
               dbus_out       <= xmove.wdata;
               dbus_oe        <= xmove.we;
            end else begin
               xmove_done <= 1'b1;
            end
         end else if (xm_busy_r && p2) begin
            if (xm_left_r == 3'h0) begin
               xm_busy_r      <= 1'b0;
               read_strobe_n  <= 1'b1;
               write_strobe_n <= 1'b1;
               dbus_oe        <= 1'b0;
               xmove_done     <= 1'b1;
               if (!xm_we_r) begin
                  xmove_rdata <= db_s2_r;
               end
            end else begin
               xm_left_r <= xm_left_r - 3'h1;
            end
         end
      end
   end

   // address pins and program fetch strobe; data move owns the bus
   always_ff @(posedge clk) begin
      if (!resetn) begin
         program_fetch_strobe_n <= 1'b1;
         ext_addr               <= 20'h00000;
      end else if (xm_busy_r || (xmove_go && p2 && xm_ext)) begin
         program_fetch_strobe_n <= 1'b1;
         if (!xm_busy_r) begin
            ext_addr <= xm_addr;
         end
      end else begin
         program_fetch_strobe_n <= ~(ext_prog & (state_r == S_EXEC));
         ext_addr               <= pc;
      end
   end

   // wishbone: ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h00000000;
      end else begin
         ack_r  <= wb_cyc_i & wb_stb_i & ~ack_r;
         rdat_r <= 32'h00000000;
         if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i) begin
            unique case (wb_adr_i)
               OFS_WAIT_CFG: rdat_r[3:0] <= wait_cfg_r;
               OFS_STATUS: begin
                  rdat_r[ST_INPROG_POS +: 5] <= inprog_r;
                  rdat_r[ST_SRC_POS +: 4]    <= last_src_r;
                  rdat_r[ST_CALL_POS]        <= (state_r == S_CALL);
               end
               default: rdat_r <= 32'h00000000;
            endcase
         end
      end
   end

   // write lands at the edge where the master sees ack
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wait_cfg_r <= WAIT_CFG_RST;
      end else if (ack_r && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
                   && wb_adr_i == OFS_WAIT_CFG) begin
         wait_cfg_r <= wb_dat_i[3:0];
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

endmodule // core_cycle_timing_irq_ack

// ### hw/cyc_timing_pkg.sv
/*
 package of the core timing and interrupt acknowledge block:
 register offsets, field positions, reset values and the carrier structs.
 assumes a 32-bit classic wishbone register bus.
*/
package cyc_timing_pkg;

   // register byte offsets
   localparam logic [3:0] OFS_WAIT_CFG = 4'h0;
   localparam logic [3:0] OFS_STATUS   = 4'h4;

   // wait configuration fields
   localparam int WS_INT_POS = 0;
   localparam int WS_EXT_POS = 2;
   localparam logic [3:0] WAIT_CFG_RST = 4'h0;

   // status fields
   localparam int ST_INPROG_POS = 0;
   localparam int ST_SRC_POS    = 8;
   localparam int ST_CALL_POS   = 12;

   // memory sizing
   localparam logic [19:0] INT_CODE_SIZE = 20'h02000;

   // source count: index 0 is the nonmaskable source
   localparam int NSRC = 15;
   localparam logic [2:0] NMI_LEVEL = 3'h5;

   // machine cycles of the hardware call
   localparam logic [1:0] CALL_CYCLES = 2'h2;

   // cycle count codes
   localparam logic [1:0] CYC1 = 2'h0;
   localparam logic [1:0] CYC2 = 2'h1;

   typedef struct packed {
      logic [1:0] cyc_code;   // 0: one, 1: two, else four machine cycles
      logic [1:0] bytes;      // 1..3 bytes fetched
      logic       return_from_interrupt_op;       // return from interrupt
      logic       ie_write;   // write to enable or priority register
   } instr_info_t;

   typedef struct packed {
      logic        we;
      logic        use_data_pointer;
      logic [15:0] data_pointer;
      logic [7:0]  index_reg;
      logic [7:0]  port_high;
      logic [3:0]  data_bank_field;
      logic [7:0]  wdata;
   } xmove_req_t;

endpackage

// ### dv/cyc_timing_sva.sv
/*
 port checks of the timing and acknowledge block.
 assumes a bind onto core_cycle_timing_irq_ack.
*/
`timescale 1ns/1ps
module cyc_timing_sva (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // sequencer
   input wire logic phase_one,
   input wire logic phase_two,
   input wire logic instr_load,
   input wire logic sfr_wr_req,
   input wire logic sfr_wr_commit,
   // interrupt call
   input wire logic irq_ack,
   input wire logic call_active,
   // memory pins
   input wire logic program_fetch_strobe_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic dbus_oe,
   input wire logic xmove_done,
   input wire logic xmove_internal
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // call lasts two machine cycles, then the routine starts
   sequence s_call_body;
      call_active [*4] ##1 !call_active;
   endsequence
   // read strobe held until released together with done; longest read is five machine cycles
   sequence s_rd_span;
      !read_strobe_n ##[1:10] (read_strobe_n && xmove_done);
   endsequence

   a_phase_fwd: assert property (phase_one |=> phase_two && !phase_one)
      else $error("phase two missing after phase one");
   a_phase_back: assert property (phase_two |=> phase_one)
      else $error("phase one missing after phase two");
   a_commit_end: assert property (sfr_wr_commit == (sfr_wr_req && phase_two))
      else $error("register write outside phase two");
   a_load_edge: assert property (instr_load |-> phase_two ##1 !instr_load)
      else $error("boundary not a single phase two clock");
   a_call_span: assert property ($rose(call_active) |-> irq_ack ##0 s_call_body)
      else $error("hardware call length wrong");
   a_fetch_excl: assert property (!program_fetch_strobe_n |-> read_strobe_n && write_strobe_n)
      else $error("fetch strobe overlaps data strobe");
   a_wr_drive: assert property (!write_strobe_n |-> dbus_oe)
      else $error("write strobe without bus drive");
   a_rd_span: assert property ($fell(read_strobe_n) |-> s_rd_span)
      else $error("read strobe not closed by done");
   a_int_quiet: assert property (xmove_done && xmove_internal |-> read_strobe_n && $past(read_strobe_n))
      else $error("internal move used the bus");
endmodule // cyc_timing_sva

bind core_cycle_timing_irq_ack cyc_timing_sva u_sva (.clk(clk), .resetn(resetn), .phase_one(phase_one),
   .phase_two(phase_two), .instr_load(instr_load), .sfr_wr_req(sfr_wr_req), .sfr_wr_commit(sfr_wr_commit),
   .irq_ack(irq_ack), .call_active(call_active), .program_fetch_strobe_n(program_fetch_strobe_n),
   .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .dbus_oe(dbus_oe),
   .xmove_done(xmove_done), .xmove_internal(xmove_internal));

// ### dv/ext_mem_model.sv
/*
 external data memory at the core's pins.
 assumes strobes and address come from registers on clk.
*/
`timescale 1ns/1ps
module ext_mem_model #(
   parameter int LAG = 0 // clocks before read data is valid
) (
   // pins from the core
   input  wire logic        clk,
   input  wire logic        read_strobe_n,
   input  wire logic        write_strobe_n,
   input  wire logic [19:0] ext_addr,
   input  wire logic [7:0]  dbus_out,
   input  wire logic        dbus_oe,
   // data toward the core
   output logic [7:0]       dbus_in
);
   logic [19:0] rd_addr, wr_addr;
   logic [7:0]  wr_data;
   logic [7:0]  last = 8'h3C;
   int          held = 0;

   // track open read; remember the byte so a released bus never repeats it
   always_ff @(posedge clk) begin
      held <= read_strobe_n ? 0 : held + 1;
      if (!read_strobe_n) rd_addr <= ext_addr;
      if (!read_strobe_n) last <= dbus_in;
   end
   // data keyed by address, held while the strobe is low
   always_comb dbus_in = (!read_strobe_n && held >= LAG) ? ext_addr[7:0] ^ 8'h5A : ~last;
   // write taken while the core drives the bus
   always_ff @(posedge clk) if (!write_strobe_n && dbus_oe) begin
      wr_addr <= ext_addr;
      wr_data <= dbus_out;
   end
endmodule // ext_mem_model

// ### dv/tb_core_cycle_timing_irq_ack.sv
/*
 self-checking bench of the timing and acknowledge block.
 assumes the bound checker and the external memory model.
*/
`timescale 1ns/1ps
module tb_core_cycle_timing_irq_ack;
   import cyc_timing_pkg::*;
   logic            clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, sfr_wr_req, xmove_go, ea_n, s;
   logic            wb_ack_o, sfr_wr_commit, phase_one, phase_two, instr_load, irq_ack, call_active;
   logic            xmove_done, xmove_internal, pfs_n, rd_n, wr_n, dbus_oe;
   logic [3:0]      wb_adr_i, irq_src, sel;
   logic [31:0]     wb_dat_i, wb_dat_o, q;
   logic [19:0]     pc, ext_addr;
   logic [7:0]      xmove_rdata, dbus_in, dbus_out;
   logic [NSRC-1:0] irq_pend, irq_lvl_hi, irq_lvl_lo;
   instr_info_t     next_instr;
   xmove_req_t      xmove;
   int              err_total, comparisons, acks, n;

   core_cycle_timing_irq_ack u_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .next_instr(next_instr), .pc(pc), .sfr_wr_req(sfr_wr_req),
      .sfr_wr_commit(sfr_wr_commit), .phase_one(phase_one), .phase_two(phase_two), .instr_load(instr_load),
      .irq_pend(irq_pend), .irq_lvl_hi(irq_lvl_hi), .irq_lvl_lo(irq_lvl_lo), .irq_ack(irq_ack),
      .irq_src(irq_src), .call_active(call_active), .xmove_go(xmove_go), .xmove(xmove),
      .xmove_done(xmove_done), .xmove_internal(xmove_internal), .xmove_rdata(xmove_rdata),
      .external_access_select_n(ea_n), .program_fetch_strobe_n(pfs_n), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .ext_addr(ext_addr), .dbus_in(dbus_in), .dbus_out(dbus_out), .dbus_oe(dbus_oe));
   ext_mem_model u_mem (.clk(clk), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .ext_addr(ext_addr),
      .dbus_out(dbus_out), .dbus_oe(dbus_oe), .dbus_in(dbus_in));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // counted on the falling edge so a task reading acks at the rising edge never races it
   always @(negedge clk) if (irq_ack === 1'b1) acks++;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // classic cycle; request held until ack is sampled
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // clocks between two instruction boundaries
   task automatic gap(output int c);
      c = 0;
      do @(posedge clk); while (instr_load !== 1'b1);
      do begin
         @(posedge clk);
         c++;
      end while (instr_load !== 1'b1 && c < 100);
      if (c >= 100) begin
         err_total++;
         $display("[ERR] %0t no instruction boundary", $time);
      end
   endtask
   task automatic wait_ack(output int c);
      c = 0;
      do begin
         @(posedge clk);
         c++;
      end while (irq_ack !== 1'b1 && c < 40);
      if (c >= 40) begin
         err_total++;
         $display("[ERR] %0t no acknowledge", $time);
      end
   endtask
   // level request held until done, then dropped so it does not restart
   task automatic mv(input xmove_req_t r);
      int k = 0;
      @(posedge clk);
      xmove    <= r;
      xmove_go <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (xmove_done !== 1'b1 && k < 40);
      xmove_go <= 1'b0;
      if (k >= 40) begin
         err_total++;
         $display("[ERR] %0t data move never done", $time);
      end
   endtask
   task automatic fetch_seen();
      s = 1'b0;
      repeat (30) begin
         @(posedge clk);
         if (pfs_n === 1'b0 && !s) chk(ext_addr, pc);
         if (pfs_n === 1'b0) s = 1'b1;
      end
   endtask

   initial begin
      int exp_c [3] = '{2, 4, 8};
      logic [4:0] st_exp [3] = '{5'h09, 5'h01, 5'h00};
      resetn     <= 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i, sfr_wr_req, xmove_go} <= 5'h00;
      wb_adr_i   <= 4'h0;
      wb_dat_i   <= 32'h0;
      sel        <= 4'hF;
      next_instr <= '{CYC1, 2'h1, 1'b0, 1'b0};
      pc         <= 20'h00100;
      {irq_pend, irq_lvl_hi, irq_lvl_lo} <= '0;
      xmove      <= '0;
      ea_n       <= 1'b1;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      // register map: reset value, read-only and unmapped
      wb(1'b0, OFS_WAIT_CFG, 32'h0);
      chk(q, {28'h0, WAIT_CFG_RST});
      wb(1'b1, OFS_STATUS, 32'hFFFF);
      wb(1'b0, OFS_STATUS, 32'h0);
      chk(q, 32'h0);
      wb(1'b0, 4'h8, 32'h0);
      chk(q, 32'h0);
      // write without byte lane zero is ignored
      sel <= 4'hE;
      wb(1'b1, OFS_WAIT_CFG, 32'hF);
      sel <= 4'hF;
      wb(1'b0, OFS_WAIT_CFG, 32'h0);
      chk(q, 32'h0);
      // one, two and four cycle instructions, no waits
      sfr_wr_req <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         next_instr.cyc_code <= 2'(k);
         gap(n);
         gap(n);
         chk(n, exp_c[k]);
      end
      // internal region one wait per byte, external two per byte
      wb(1'b1, OFS_WAIT_CFG, 32'h9);
      wb(1'b0, OFS_WAIT_CFG, 32'h0);
      chk(q, 32'h9);
      next_instr <= '{CYC2, 2'h2, 1'b0, 1'b0};
      gap(n);
      gap(n);
      chk(n, 8);
      pc <= 20'h14000;
      next_instr <= '{CYC1, 2'h3, 1'b0, 1'b0};
      gap(n);
      gap(n);
      chk(n, 14);
      fetch_seen();
      chk(s, 1'b1);
      pc <= 20'h00100;
      repeat (20) @(posedge clk);
      fetch_seen();
      chk(s, 1'b0);
      ea_n <= 1'b0;
      repeat (8) @(posedge clk);
      fetch_seen();
      chk(s, 1'b1);
      ea_n <= 1'b1;
      wb(1'b1, OFS_WAIT_CFG, 32'h0);
      next_instr <= '{CYC1, 2'h1, 1'b0, 1'b0};
      // same level tie, then same level while that routine runs
      irq_pend <= 15'h0048;
      wait_ack(n);
      chk(n >= 2 && n <= 14, 1'b1);
      chk(irq_src, 4'h3);
      irq_pend <= 15'h0004;
      n = acks;
      repeat (30) @(posedge clk);
      chk(acks, n);
      // two levels at once: level four beats level two
      irq_lvl_lo <= 15'h1210;
      irq_lvl_hi <= 15'h1200;
      irq_pend <= 15'h0214;
      wait_ack(n);
      chk(irq_src, 4'h9);
      irq_pend <= 15'h0005;
      wait_ack(n);
      chk(irq_src, 4'h0);
      irq_pend <= 15'h1004;
      n = acks;
      repeat (30) @(posedge clk);
      chk(acks, n);
      irq_pend <= '0;
      wb(1'b0, OFS_STATUS, 32'h0);
      chk(q[12:0], 13'h0019);
      // each return closes the highest open level
      for (int k = 0; k < 3; k++) begin
         next_instr.return_from_interrupt_op <= 1'b1;
         do @(posedge clk); while (instr_load !== 1'b1);
         next_instr.return_from_interrupt_op <= 1'b0;
         gap(n);
         wb(1'b0, OFS_STATUS, 32'h0);
         chk(q[4:0], st_exp[k]);
      end
      // request seen only under enable writes is forgotten
      next_instr.ie_write <= 1'b1;
      repeat (4) @(posedge clk);
      n = acks;
      irq_pend <= 15'h0020;
      repeat (20) @(posedge clk);
      irq_pend <= '0;
      repeat (4) @(posedge clk);
      next_instr.ie_write <= 1'b0;
      repeat (30) @(posedge clk);
      chk(acks, n);
      // external reads by pointer and by port page, a write, an internal move
      mv('{1'b0, 1'b1, 16'h8031, 8'h00, 8'h00, 4'h0, 8'h00});
      chk({xmove_internal, xmove_rdata}, 9'h06B);
      chk(u_mem.rd_addr, 20'h08031);
      mv('{1'b0, 1'b0, 16'h0000, 8'h34, 8'h90, 4'h1, 8'h00});
      chk({xmove_internal, xmove_rdata}, 9'h06E);
      chk(u_mem.rd_addr, 20'h19034);
      wb(1'b1, OFS_WAIT_CFG, 32'h4);
      mv('{1'b1, 1'b1, 16'h4567, 8'h00, 8'h00, 4'h2, 8'hA5});
      chk({u_mem.wr_addr, u_mem.wr_data}, 28'h24567A5);
      mv('{1'b0, 1'b1, 16'h0100, 8'h00, 8'h00, 4'h0, 8'h00});
      chk(xmove_internal, 1'b1);
      close_out();
   end

   // hang guard: the sequence needs well under a thousand clocks of the 12500 allowed
   initial begin
      #100000;
      err_total++;
      $display("[ERR] %0t run did not finish", $time);
      close_out();
   end
endmodule // tb_core_cycle_timing_irq_ack
